/* File: hdl/fans_consts.vh */
// Constants for the fan alarm status and nonvolatile transfer registers
`ifndef FANS_CONSTS_VH
`define FANS_CONSTS_VH
`define FANS_ADDR_W 8
`define FANS_DATA_W 8
`define FANS_OFF_STATUS 8'h5a
`define FANS_OFF_XFER 8'h5b
`define FANS_OFF_TEMP_CFG 8'h60
`define FANS_OFF_TACH_CFG 8'h61
`define FANS_BIT_RHA 3
`define FANS_BIT_REMOTE_OVERTEMP_ALARM 2
`define FANS_BIT_T2A 1
`define FANS_BIT_T1A 0
`define FANS_BIT_DIR 7
`define FANS_BLK_MSB 4
`define FANS_NBLK 5
`define FANS_XFER_RESET 8'h00
`define FANS_XFER_WMASK 8'h9f
`define FANS_CFG_RESET 8'h00
`define FANS_BLK_BYTES 5'h10
`endif

/* File: hdl/fans_tach_alarm.v */
// One tachometer channel alarm condition
`timescale 1ns/100ps
module fans_tach_alarm (
  input wire running_mode_i,
  input wire running_i,
  input wire [15:0] count_i,
  input wire [15:0] threshold_i,
  input wire count_valid_i,
  input wire overflow_i,
  input wire stopped_i,
  output wire fault_o
);
  // Slow fan: count above threshold; overflow or stall also count as fault
  wire pulse_fault;
  assign pulse_fault = (count_valid_i && (count_i > threshold_i)) ||
    overflow_i || stopped_i;
  assign fault_o = running_mode_i ? ~running_i : pulse_fault;
endmodule // fans_tach_alarm

/* File: hdl/fans_regs.v */
// Alarm status and nonvolatile transfer register bank
// Behaviour
// - Status bit 3 is set while remote temperature is above the high point.
// - Status bit 2 is set while remote temperature is above the overtemp point.
// - In pulse mode bit 1 is set while a valid channel 2 count is above threshold.
// - In pulse mode bit 0 is set while a valid channel 1 count is above threshold.
// - In pulse mode a tach alarm is set on low speed, no rotation or counter overflow.
// - In running-detect mode a tach alarm is set while the fan does not run.
// - Transfer bit 7 chooses direction: 0 stores volatile to nvm, 1 loads nvm.
// - Transfer bits 4..0 each select a 16-byte block from 00h up to 4Fh.
// - Reading the transfer register clears it to zero.
// - The transfer register resets to all zeros.
// - Reading status clears alarm bits; a still-present fault sets them again.
`timescale 1ns/100ps
`include "fans_consts.vh"
module fans_regs (
  input wire clk_i,
  input wire rst_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire signed [15:0] remote_temp_i,
  input wire signed [15:0] remote_high_sp_i,
  input wire signed [15:0] remote_ot_sp_i,
  input wire [15:0] tach_threshold_i,
  input wire [15:0] first_tach_count_i,
  input wire [15:0] second_tach_count_i,
  input wire first_tach_valid_i,
  input wire second_tach_valid_i,
  input wire first_tach_ovf_i,
  input wire second_tach_ovf_i,
  input wire first_tach_stop_i,
  input wire second_tach_stop_i,
  input wire first_tach_input_i,
  input wire second_tach_input_i,
  input wire first_running_mode_i,
  input wire second_running_mode_i,
  input wire first_run_level_i,
  input wire second_run_level_i,
  input wire nvm_ready_i,
  output reg nvm_start_o,
  output reg nvm_dir_o,
  output reg [6:0] nvm_base_o,
  input wire nvm_block_done_i,
  output wire nvm_busy_o,
  output wire [3:0] alarm_o
);
  // ==========================================================
  // Address decode
  function is_addr;
    input [7:0] a;
    input [7:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  // ==========================================================
  // Alarm conditions
  wire first_fault;
  wire second_fault;
  wire [3:0] fault_now;
  fans_tach_alarm u_first (
    .running_mode_i(first_running_mode_i),
    .running_i(first_run_level_i),
    .count_i(first_tach_count_i),
    .threshold_i(tach_threshold_i),
    .count_valid_i(first_tach_valid_i),
    .overflow_i(first_tach_ovf_i),
    .stopped_i(first_tach_stop_i),
    .fault_o(first_fault)
  );
  fans_tach_alarm u_second (
    .running_mode_i(second_running_mode_i),
    .running_i(second_run_level_i),
    .count_i(second_tach_count_i),
    .threshold_i(tach_threshold_i),
    .count_valid_i(second_tach_valid_i),
    .overflow_i(second_tach_ovf_i),
    .stopped_i(second_tach_stop_i),
    .fault_o(second_fault)
  );
  assign fault_now[`FANS_BIT_RHA] =
    (remote_temp_i > remote_high_sp_i);
  assign fault_now[`FANS_BIT_REMOTE_OVERTEMP_ALARM] =
    (remote_temp_i > remote_ot_sp_i);
  assign fault_now[`FANS_BIT_T2A] = second_fault;
  assign fault_now[`FANS_BIT_T1A] = first_fault;

  // ==========================================================
  // Alarm status, latched and cleared on read
  reg [3:0] alarm_q;
  reg [3:0] alarm_d;
  wire rd_status;
  assign rd_status = rd_i && is_addr(addr_i, `FANS_OFF_STATUS);
  always @* begin
    // A fault present in the read cycle survives the clear
    alarm_d = (rd_status ? 4'h0 : alarm_q) | fault_now;
  end
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_q <= 4'h0;
    end else begin
      alarm_q <= alarm_d;
    end
  end
  assign alarm_o = alarm_q;

  // ==========================================================
  // Transfer control and block sequencer
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ = 2'h1;
  localparam ST_WAIT = 2'h2;
  reg [7:0] xfer_q;
  reg [7:0] xfer_d;
  reg [4:0] pend_q;
  reg [4:0] pend_d;
  reg [2:0] blk_q;
  reg [2:0] blk_d;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg start_d;
  reg dir_d;
  reg [6:0] base_d;
  wire wr_xfer;
  wire rd_xfer;
  wire [4:0] wr_blocks;
  wire [2:0] next_blk;
  wire pend_empty;

  // Lowest set select bit first; an empty mask gives block 0
  function [2:0] lowest_blk;
    input [4:0] mask;
    integer k;
    begin
      lowest_blk = 3'h0;
      for (k = `FANS_NBLK - 1; k >= 0; k = k - 1) begin
        if (mask[k]) begin
          lowest_blk = k[2:0];
        end
      end
    end
  endfunction

  // Byte address of the first location of a block
  function [6:0] blk_base;
    input [2:0] blk;
    begin
      blk_base = {blk, 4'h0};
    end
  endfunction

  assign wr_xfer = wr_i && is_addr(addr_i, `FANS_OFF_XFER);
  assign rd_xfer = rd_i && is_addr(addr_i, `FANS_OFF_XFER);
  assign wr_blocks = wdata_i[`FANS_BLK_MSB:0];
  assign next_blk = lowest_blk(pend_q);
  assign pend_empty = (pend_q == 5'h00);
  assign nvm_busy_o = (st_q != ST_IDLE);

  // Register value: a write wins, a read empties it
  always @* begin
    xfer_d = xfer_q;
    if (wr_xfer) begin
      xfer_d = wdata_i & `FANS_XFER_WMASK;
    end else if (rd_xfer) begin
      xfer_d = 8'h00;
    end
  end

  always @* begin
    st_d = st_q;
    pend_d = pend_q;
    blk_d = blk_q;
    start_d = 1'b0;
    dir_d = nvm_dir_o;
    base_d = nvm_base_o;
    case (st_q)
      ST_IDLE: begin
        // Blocks latched at the write; writes made while busy update the register but start no transfer
        if (wr_xfer && (wr_blocks != 5'h00)) begin
          pend_d = wr_blocks;
          dir_d = wdata_i[`FANS_BIT_DIR];
          st_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (nvm_ready_i) begin
          blk_d = next_blk;
          base_d = blk_base(next_blk);
          pend_d[next_blk] = 1'b0;
          start_d = 1'b1;
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (nvm_block_done_i) begin
          st_d = pend_empty ? ST_IDLE : ST_REQ;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xfer_q <= `FANS_XFER_RESET;
    end else begin
      xfer_q <= xfer_d;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q <= 5'h00;
      blk_q <= 3'h0;
      st_q <= ST_IDLE;
      nvm_start_o <= 1'b0;
      nvm_dir_o <= 1'b0;
      nvm_base_o <= 7'h00;
    end else begin
      pend_q <= pend_d;
      blk_q <= blk_d;
      st_q <= st_d;
      nvm_start_o <= start_d;
      nvm_dir_o <= dir_d;
      nvm_base_o <= base_d;
    end
  end

  // ==========================================================
  // Read data, valid the cycle after the strobe
  // Unmapped offsets read as zero so software sees no stale value
  function [7:0] read_mux;
    input [7:0] a;
    input [3:0] alarm;
    input [7:0] xfer;
    begin
      if (is_addr(a, `FANS_OFF_STATUS)) begin
        read_mux = {4'h0, alarm};
      end else if (is_addr(a, `FANS_OFF_XFER)) begin
        read_mux = xfer;
      end else begin
        read_mux = 8'h00;
      end
    end
  endfunction

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= read_mux(addr_i, alarm_q, xfer_q);
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // fans_regs

/* File: test/fans_regs_assertions.sv */
// Assertion checker for the fan alarm register bank
`timescale 1ns/100ps
module fans_regs_chk (
  input logic clk_i,
  input logic rst_n_i,
  input logic [7:0] addr_i,
  input logic rd_i,
  input logic [7:0] rdata_o,
  input logic signed [15:0] remote_temp_i,
  input logic signed [15:0] remote_high_sp_i,
  input logic signed [15:0] remote_ot_sp_i,
  input logic first_running_mode_i,
  input logic first_run_level_i,
  input logic second_tach_ovf_i,
  input logic nvm_start_o,
  input logic nvm_busy_o,
  input logic [6:0] nvm_base_o,
  input logic [3:0] alarm_o
);
  // =====
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence xrd; rd_i && addr_i == 8'h5b; endsequence
  AST_RHA: assert property (remote_temp_i > remote_high_sp_i
    |-> ##[1:2] alarm_o[3]) else $error("high alarm");
  AST_REMOTE_OVERTEMP_ALARM: assert property (remote_temp_i > remote_ot_sp_i
    |-> ##[1:2] alarm_o[2]) else $error("ot alarm");
  AST_RUN: assert property (first_running_mode_i && !first_run_level_i
    |-> ##[1:2] alarm_o[0]) else $error("run alarm");
  AST_OVF: assert property (second_tach_ovf_i
    |-> ##[1:2] alarm_o[1]) else $error("ovf alarm");
  AST_STAT: assert property (rd_i && addr_i == 8'h5a
    |=> rdata_o[7:4] == 4'h0) else $error("status high");
  AST_RSV: assert property (xrd
    |=> rdata_o[6:5] == 2'h0) else $error("reserved");
  // A second read sees what the first one cleared
  AST_CLR: assert property (xrd ##1 xrd
    |=> rdata_o == 8'h00) else $error("no clear");
  AST_BUSY: assert property (nvm_start_o
    |-> nvm_busy_o && nvm_base_o[3:0] == 4'h0) else $error("start");
endmodule // fans_regs_chk
bind fans_regs fans_regs_chk chk (.*);

/* File: test/fans_regs_tb.sv */
// Self-checking bench for the fan alarm register bank
`timescale 1ns/100ps
module fans_regs_tb;
  logic clk_i = '0, rst_n_i = '0, wr_i = '0, rd_i = '0;
  logic [7:0] addr_i = '0, wdata_i = '0, rdata_o;
  logic signed [15:0] remote_temp_i = '0, remote_high_sp_i = 16'h0032;
  logic signed [15:0] remote_ot_sp_i = 16'h00c8;
  logic [15:0] tach_threshold_i = 16'h0064;
  logic [15:0] first_tach_count_i = '0, second_tach_count_i = '0;
  logic first_tach_valid_i = '0, second_tach_valid_i = '0;
  logic first_tach_ovf_i = '0, second_tach_ovf_i = '0;
  logic first_tach_stop_i = '0, second_tach_stop_i = '0;
  logic first_tach_input_i = '0, second_tach_input_i = '0;
  logic first_running_mode_i = '0, second_running_mode_i = '0;
  logic first_run_level_i = '0, second_run_level_i = '0;
  logic nvm_ready_i = '0, nvm_block_done_i = '0;
  logic nvm_start_o, nvm_dir_o, nvm_busy_o;
  logic [6:0] nvm_base_o;
  logic [3:0] alarm_o;
  int errors = 0, checked = 0, n;
  fans_regs dut (.*);
  initial forever #2 clk_i = ~clk_i;
  // =====
  // Tasks
  task chk(input string s, input logic [7:0] e, v);
    checked++;
    if (v !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", s, e, v);
    end
  endtask
  task wr(input logic [7:0] a, d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= '1;
    @(posedge clk_i);
    wr_i <= '0;
    #1;
  endtask
  task rd(input logic [7:0] a, e);
    addr_i <= a;
    rd_i <= '1;
    @(posedge clk_i);
    rd_i <= '0;
    #1 chk("rdata", e, rdata_o);
  endtask
  // Alarms latch a cycle or two after their cause
  task st(input logic [7:0] e);
    repeat (2) @(posedge clk_i);
    #1 chk("alarm", e, {4'h0, alarm_o});
    rd(8'h5a, e);
  endtask
  task blk(input logic [7:0] b, d);
    n = 0;
    while (nvm_start_o !== 1'h1 && n < 30) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk("base", b, {1'h0, nvm_base_o});
    chk("dir", d, {7'h0, nvm_dir_o});
    nvm_block_done_i <= '1;
    @(posedge clk_i);
    nvm_block_done_i <= '0;
    #1;
  endtask
  task give_verdict;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #40000 errors++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    #1 rst_n_i <= '1;
    rd(8'h5b, 8'h00);
    remote_temp_i <= 16'h0064;
    st(8'h08);
    remote_temp_i <= 16'h0032;
    st(8'h08);
    rd(8'h5a, 8'h00);
    remote_temp_i <= 16'h00c9;
    st(8'h0c);
    remote_temp_i <= 16'h00c8;
    st(8'h0c);
    rd(8'h5a, 8'h08);
    remote_temp_i <= '0;
    first_tach_valid_i <= '1;
    second_tach_valid_i <= '1;
    first_tach_count_i <= 16'h0064;
    second_tach_count_i <= 16'h0065;
    st(8'h0a);
    second_tach_count_i <= 16'h0064;
    st(8'h02);
    rd(8'h5a, 8'h00);
    first_tach_ovf_i <= '1;
    second_tach_stop_i <= '1;
    st(8'h03);
    first_tach_ovf_i <= '0;
    second_tach_stop_i <= '0;
    first_running_mode_i <= '1;
    second_running_mode_i <= '1;
    second_run_level_i <= '1;
    st(8'h03);
    first_run_level_i <= '1;
    st(8'h01);
    rd(8'h5a, 8'h00);
    wr(8'h5b, 8'hf3);
    repeat (3) @(posedge clk_i);
    #1 chk("start", 8'h00, {7'h0, nvm_start_o});
    nvm_ready_i <= '1;
    blk(8'h00, 8'h01);
    blk(8'h10, 8'h01);
    blk(8'h40, 8'h01);
    rd(8'h5b, 8'h93);
    chk("busy", 8'h00, {7'h0, nvm_busy_o});
    rd(8'h5b, 8'h00);
    wr(8'h5b, 8'h10);
    blk(8'h40, 8'h00);
    wr(8'h70, 8'hff);
    rd(8'h70, 8'h00);
    give_verdict;
  end
endmodule // fans_regs_tb
